/* File: pakb_defs.svh */
`ifndef PAKB_DEFS_SVH
`define PAKB_DEFS_SVH

`define PAKB_ADDR_W          8
`define PAKB_OFF_LATCH       8'h00
`define PAKB_OFF_DIR         8'h04
`define PAKB_OFF_EDGE        8'h08
`define PAKB_OFF_ENABLE      8'h0c
`define PAKB_OFF_FLAG        8'h10
`define PAKB_OFF_CTRL        8'h14
`define PAKB_OFF_PIN         8'h18
`define PAKB_CTRL_IMASK_BIT  0
`define PAKB_CTRL_WAIT_BIT   1
`define PAKB_DIR_RESET       8'h00
`define PAKB_EDGE_RESET      8'h00
`define PAKB_ENABLE_RESET    8'h00
`define PAKB_FLAG_RESET      8'h00
`define PAKB_CTRL_RESET      8'h01

`endif

/* File: pakb_pkg.sv */
package pakb_pkg;
    typedef logic [7:0] pakb_byte_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pakb_bus_t;
endpackage : pakb_pkg

/* File: pakb_edge_unit.sv */
`timescale 1ns/1ns
module pakb_edge_unit
    import pakb_pkg::*;
(
    input  wire logic sys_clk_i,
    input  wire logic srst_i,
    input  wire logic pin_i,
    input  wire logic polarity_i,
    input  wire logic flag_clr_i,
    output logic      flag_o,
    output logic      pin_sync_o
);
    logic meta;
    logic sync;
    logic prev;
    logic prev_pol;
    logic flag;
    logic next_flag;
    logic level_prev;
    logic level_now;
    logic hit;
    logic primed;

    always_comb
    begin
        level_prev = prev_pol ? prev : ~prev;
        level_now  = polarity_i ? sync : ~sync;
        // No edge until history holds a real sample after reset
        hit        = primed & level_now & ~level_prev; // [R8] [R9] [R14]
        next_flag  = hit | (flag & ~flag_clr_i); // [R11]
    end

    always_ff @(posedge sys_clk_i)
    begin
        meta     <= pin_i;
        sync     <= meta; // [R14]
        prev     <= sync;
        prev_pol <= polarity_i;
        if (srst_i)
        begin
            flag   <= 1'b0;
            primed <= 1'b0;
        end
        else
        begin
            flag   <= next_flag;
            primed <= 1'b1;
        end
    end

    assign flag_o     = flag;
    assign pin_sync_o = sync;
endmodule : pakb_edge_unit

/* File: pakb_port.sv */
`timescale 1ns/1ns
`include "pakb_defs.svh"
// Notes on behaviour
// [R1] Eight bidirectional lines, each with data and direction bits.
// [R2] Direction one drives pin from data bit; zero makes it input.
// [R3] Reset clears direction bits; data latch keeps its contents.
// [R4] Eight edge sources, one per pin, each with pending flag.
// [R5] Keyboard request is OR of the eight pending flags.
// [R6] Global mask bit set blocks delivery of the keyboard interrupt.
// [R7] Each source individually masked by its own enable bit.
// [R8] Polarity one triggers rising edge, zero triggers falling edge.
// [R9] Changing polarity with matching pin level registers an edge.
// [R10] Software loads data before setting direction to avoid glitches.
// [R11] Flag sets even if disabled; writing one clears that flag.
// [R12] Enable one lets the flag request; zero blocks it.
// [R13] Edge detection and interrupt keep working in wait state.
// [R14] Pins synchronised; edges from current versus previous sample.
module pakb_port
    import pakb_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       srst_i,
    input  wire logic [7:0] bus_addr_i,
    input  wire logic [7:0] bus_wdata_i,
    input  wire logic       bus_wr_i,
    input  wire logic       bus_rd_i,
    output logic      [7:0] bus_rdata_o,
    input  wire logic [7:0] keypad_pins_i,
    output logic      [7:0] keypad_pins_o,
    output logic      [7:0] keypad_pins_oe_o,
    output logic            kbd_irq_o
);
    pakb_bus_t  bus;
    pakb_byte_t latch;
    pakb_byte_t dir;
    pakb_byte_t edge_sel;
    pakb_byte_t enable;
    pakb_byte_t ctrl;
    pakb_byte_t rdata;
    pakb_byte_t pins_o;
    pakb_byte_t pins_oe;
    logic       irq;
    pakb_byte_t next_latch;
    pakb_byte_t next_dir;
    pakb_byte_t next_edge;
    pakb_byte_t next_enable;
    pakb_byte_t next_ctrl;
    pakb_byte_t next_rdata;
    logic       next_irq;
    pakb_byte_t flag;
    pakb_byte_t flag_clr;
    pakb_byte_t pin_sync;

    assign bus.addr  = bus_addr_i;
    assign bus.wdata = bus_wdata_i;
    assign bus.wr    = bus_wr_i;
    assign bus.rd    = bus_rd_i;

    always_comb
    begin
        flag_clr = (bus.wr && bus.addr == `PAKB_OFF_FLAG) ? bus.wdata : 8'h00; // [R11]
    end

    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_edge
            pakb_edge_unit u_edge (
                .sys_clk_i  (sys_clk_i),
                .srst_i     (srst_i),
                .pin_i      (keypad_pins_i[g]),
                .polarity_i (edge_sel[g]),
                .flag_clr_i (flag_clr[g]),
                .flag_o     (flag[g]), // [R4]
                .pin_sync_o (pin_sync[g])
            );
        end
    endgenerate

    always_comb
    begin
        next_latch  = latch;
        next_dir    = dir;
        next_edge   = edge_sel;
        next_enable = enable;
        next_ctrl   = ctrl;
        if (bus.wr)
        begin
            case (bus.addr)
                `PAKB_OFF_LATCH:  next_latch  = bus.wdata; // [R1]
                `PAKB_OFF_DIR:    next_dir    = bus.wdata; // [R1]
                `PAKB_OFF_EDGE:   next_edge   = bus.wdata; // [R8]
                `PAKB_OFF_ENABLE: next_enable = bus.wdata; // [R7]
                `PAKB_OFF_CTRL:   next_ctrl   = {6'h00, bus.wdata[1:0]};
                default:          next_ctrl   = ctrl;
            endcase
        end
        next_rdata = 8'h00;
        if (bus.rd)
        begin
            case (bus.addr)
                `PAKB_OFF_LATCH:  next_rdata = latch;
                `PAKB_OFF_DIR:    next_rdata = dir;
                `PAKB_OFF_EDGE:   next_rdata = edge_sel;
                `PAKB_OFF_ENABLE: next_rdata = enable;
                `PAKB_OFF_FLAG:   next_rdata = flag;
                `PAKB_OFF_CTRL:   next_rdata = ctrl;
                `PAKB_OFF_PIN:    next_rdata = pin_sync;
                default:          next_rdata = 8'h00;
            endcase
        end
        // Wait bit only informs software; detection never stops
        next_irq = (|(flag & enable)) & ~ctrl[`PAKB_CTRL_IMASK_BIT]; // [R5] [R6] [R12] [R13]
    end

    always_ff @(posedge sys_clk_i)
    begin
        latch   <= next_latch; // [R3]
        rdata   <= next_rdata;
        pins_o  <= next_latch; // [R2]
        if (srst_i)
        begin
            dir     <= `PAKB_DIR_RESET; // [R3]
            pins_oe <= `PAKB_DIR_RESET;
            edge_sel <= `PAKB_EDGE_RESET;
            enable  <= `PAKB_ENABLE_RESET;
            ctrl    <= `PAKB_CTRL_RESET;
            irq     <= 1'b0;
        end
        else
        begin
            dir      <= next_dir;
            pins_oe  <= next_dir; // [R2]
            edge_sel <= next_edge;
            enable   <= next_enable;
            ctrl     <= next_ctrl;
            irq      <= next_irq;
        end
    end

    assign bus_rdata_o      = rdata;
    assign keypad_pins_o    = pins_o;
    assign keypad_pins_oe_o = pins_oe;
    assign kbd_irq_o        = irq;
endmodule : pakb_port

/* File: pakb_monitor.sv */
`timescale 1ns/1ns
module pakb_monitor (
    input wire logic       sys_clk_i,
    input wire logic       srst_i,
    input wire logic [7:0] bus_addr_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic       bus_wr_i,
    input wire logic       bus_rd_i,
    input wire logic [7:0] bus_rdata_o,
    input wire logic [7:0] keypad_pins_i,
    input wire logic [7:0] keypad_pins_o,
    input wire logic [7:0] keypad_pins_oe_o,
    input wire logic       kbd_irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    logic       gm;
    logic [7:0] en;
    wire        wdir = bus_wr_i && bus_addr_i == 8'h04;
    // Shadow of global mask and enables
    always_ff @(posedge sys_clk_i)
        if (srst_i) {gm, en} <= 9'h100;
        else if (bus_wr_i && bus_addr_i == 8'h14) gm <= bus_wdata_i[0];
        else if (bus_wr_i && bus_addr_i == 8'h0c) en <= bus_wdata_i;
    a_dir_write: assert property (wdir |=> keypad_pins_oe_o == $past(bus_wdata_i))
        else $error("dir write");
    a_dir_hold: assert property (!wdir |=> $stable(keypad_pins_oe_o))
        else $error("dir hold");
    a_dir_reset: assert property ($fell(srst_i) |-> keypad_pins_oe_o == 8'h00)
        else $error("dir reset");
    a_latch_write: assert property (bus_wr_i && bus_addr_i == 8'h00
        |=> keypad_pins_o == $past(bus_wdata_i)) else $error("latch");
    a_dir_read: assert property ($past(bus_rd_i && bus_addr_i == 8'h04)
        |-> bus_rdata_o == keypad_pins_oe_o) else $error("dir read");
    a_rdata_idle: assert property (!$past(bus_rd_i) |-> bus_rdata_o == 8'h00)
        else $error("rdata idle");
    a_irq_mask: assert property ($past(gm) |-> !kbd_irq_o)
        else $error("irq masked");
    a_irq_enable: assert property ($past(en) == 8'h00 |-> !kbd_irq_o)
        else $error("irq disabled");
    c_irq: cover property ($rose(kbd_irq_o));
    c_dir: cover property (wdir);
    c_rst: cover property ($fell(srst_i));
endmodule : pakb_monitor
bind pakb_port pakb_monitor mon_u (.*);

/* File: pakb_keys.sv */
`timescale 1ns/1ns
module pakb_keys (
    input  wire logic [7:0] key_i,
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_i,
    output logic      [7:0] pins_o
);
    // Driven bits follow the port, the rest the keys
    assign pins_o = (oe_i & drv_i) | (~oe_i & key_i);
endmodule : pakb_keys

/* File: tb.sv */
`timescale 1ns/1ns
module tb;
    typedef struct {logic [7:0] a, d, e;} pakb_row_t;
    logic       sys_clk_i, srst_i, wr, rd, irq;
    logic [7:0] addr, wd, rdata, key, po, oe;
    wire  [7:0] pins;
    int         n_fail, num_checks, cyc;
    pakb_row_t  rows[5] = '{'{8'h00, 8'h3c, 8'h3c}, '{8'h08, 8'h3c, 8'h3c},
        '{8'h0c, 8'h81, 8'h81}, '{8'h14, 8'hfe, 8'h02}, '{8'h20, 8'h55, 8'h00}};
    pakb_port dut_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .bus_addr_i(addr),
        .bus_wdata_i(wd), .bus_wr_i(wr), .bus_rd_i(rd), .bus_rdata_o(rdata),
        .keypad_pins_i(pins), .keypad_pins_o(po), .keypad_pins_oe_o(oe), .kbd_irq_o(irq));
    pakb_keys key_u (.key_i(key), .drv_i(po), .oe_i(oe), .pins_o(pins));
    task automatic chk(input string s, input logic [7:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge sys_clk_i);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, e);
        @(posedge sys_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask : rd_reg
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    initial
    begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_fail++;
            report_and_stop();
        end
    end
    initial
    begin
        {wr, rd, addr, wd, key, n_fail, num_checks, cyc} = '0;
        srst_i = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        rd_reg(8'h04, 8'h00);
        rd_reg(8'h10, 8'h00);
        rd_reg(8'h14, 8'h01);
        foreach (rows[i])
        begin
            wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a, rows[i].e);
        end
        $display("test registers done");
        wr_reg(8'h0c, 8'h00);
        wr_reg(8'h08, 8'h00);
        repeat (6) @(posedge sys_clk_i);
        rd_reg(8'h10, 8'h3c);
        wr_reg(8'h10, 8'hff);
        key <= 8'hff;
        repeat (6) @(posedge sys_clk_i);
        rd_reg(8'h10, 8'h00);
        rd_reg(8'h18, 8'hff);
        wr_reg(8'h08, 8'h0f);
        repeat (6) @(posedge sys_clk_i);
        rd_reg(8'h10, 8'h0f);
        wr_reg(8'h10, 8'hff);
        key <= 8'h00;
        repeat (6) @(posedge sys_clk_i);
        rd_reg(8'h10, 8'hf0);
        rd_reg(8'h18, 8'h00);
        chk("irq", 8'h00, {7'h00, irq});
        wr_reg(8'h0c, 8'h10);
        repeat (2) @(posedge sys_clk_i);
        #1 chk("irq", 8'h01, {7'h00, irq});
        wr_reg(8'h14, 8'h01);
        repeat (2) @(posedge sys_clk_i);
        #1 chk("irq", 8'h00, {7'h00, irq});
        wr_reg(8'h14, 8'h00);
        repeat (2) @(posedge sys_clk_i);
        #1 chk("irq", 8'h01, {7'h00, irq});
        wr_reg(8'h10, 8'h10);
        repeat (2) @(posedge sys_clk_i);
        rd_reg(8'h10, 8'he0);
        chk("irq", 8'h00, {7'h00, irq});
        $display("test edges done");
        wr_reg(8'h00, 8'h5a);
        wr_reg(8'h04, 8'hff);
        #1 chk("oe", 8'hff, oe);
        chk("drive", 8'h5a, po);
        @(posedge sys_clk_i);
        srst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        #1 chk("oe", 8'h00, oe);
        chk("drive", 8'h5a, po);
        rd_reg(8'h10, 8'h00);
        rd_reg(8'h14, 8'h01);
        $display("test reset done");
        report_and_stop();
    end
endmodule : tb
